// ==== hdl/dimr_core.sv ====
// Our own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/10ps
// ============================================================
// Behaviour
// - Mode writes never disturb the other mode registers
// - Decode burst length, type, CAS latency
// - Test mode, DLL reset, write recovery fields
// - Decode extended register 1 fields
// - A11 enables read strobe, default off
// - Self refresh stops DLL, exit resets it
module dimr_core
  import dimr_pkg::*;
#(
  parameter int LOCK_CLKS = DLL_LOCK_CLKS
)
(
  // System
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Memory command pins
  input wire logic memClk,
  input wire logic cke,
  input wire logic csN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic [BA_W-1:0] ba,
  input wire logic [ADDR_W-1:0] addr,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Status
  output logic dllOn,
  output logic dllLocked,
  output logic selfRefresh
);
  localparam int LOCK_W = $clog2(LOCK_CLKS + 1);
  localparam logic [LOCK_W-1:0] LOCK_LAST = LOCK_W'(LOCK_CLKS - 1);
  localparam logic [LOCK_W-1:0] LOCK_ONE = LOCK_W'(1);

  // ============================================================
  // Pin synchronisation and link clock edge
  logic [SYNC_W-1:0] pinSync;
  logic sClk;
  logic sCke;
  logic [CMD_W-1:0] sCmd;
  logic [BA_W-1:0] sBa;
  logic [ADDR_W-1:0] sAddr;

  dimr_sync #(.WIDTH(SYNC_W)) pinSyncInst (
    .clk(mclk),
    .rst(rst),
    .ce(ce),
    .din({memClk, cke, csN, rasN, casN, weN, ba, addr}),
    .dout(pinSync)
  );

  assign {sClk, sCke, sCmd, sBa, sAddr} = pinSync;

  // ============================================================
  // Link state
  logic clkPrev_reg;
  logic clkPrev_next;
  logic ckePrev_reg;
  logic ckePrev_next;
  logic [ADDR_W-1:0] mr_reg;
  logic [ADDR_W-1:0] mr_next;
  logic [ADDR_W-1:0] emr1_reg;
  logic [ADDR_W-1:0] emr1_next;
  logic [ADDR_W-1:0] emr2_reg;
  logic [ADDR_W-1:0] emr2_next;
  logic [ADDR_W-1:0] emr3_reg;
  logic [ADDR_W-1:0] emr3_next;
  logic [3:0] written_reg;
  logic [3:0] written_next;
  logic badBurst_reg;
  logic badBurst_next;
  dimr_dll_e dll_reg;
  dimr_dll_e dll_next;
  logic [LOCK_W-1:0] lockCnt_reg;
  logic [LOCK_W-1:0] lockCnt_next;
  logic sref_next;
  logic dllOn_next;
  logic dllLocked_next;
  logic enable_reg;
  logic linkEdge;
  logic modeWrite;
  logic srEntry;
  logic srExit;
  logic dpWrite_reg;
  logic [7:0] dpAddr_reg;
  logic badBurstClr;

  // Pins are taken at the first mclk edge after the link edge; they must hold that long
  assign linkEdge = ce && sClk && !clkPrev_reg;
  // A mode write only counts with CKE high at this and the previous edge
  assign modeWrite = linkEdge && enable_reg && ckePrev_reg && sCke && !selfRefresh
                     && sCmd == CMD_MODE;
  assign srEntry = linkEdge && ckePrev_reg && !sCke && !selfRefresh && sCmd == CMD_REFRESH;
  assign srExit = linkEdge && selfRefresh && sCke;
  assign badBurstClr = ce && dpWrite_reg && dpAddr_reg == OFF_STATUS && hwdata[ST_BADBL];

  always_comb
  begin
    clkPrev_next = ce ? sClk : clkPrev_reg;
    ckePrev_next = linkEdge ? sCke : ckePrev_reg;
    mr_next = mr_reg;
    emr1_next = emr1_reg;
    emr2_next = emr2_reg;
    emr3_next = emr3_reg;
    written_next = written_reg;
    badBurst_next = badBurst_reg && !badBurstClr;
    dll_next = dll_reg;
    lockCnt_next = lockCnt_reg;
    sref_next = selfRefresh;
    // Each write replaces the whole addressed register and sets its written bit; MR writes can flag a bad burst, MR and EMR1 writes move the DLL
    if (modeWrite)
    begin
      written_next[sBa[1:0]] = 1'b1;
      case (sBa)
        BA_MR:
        begin
          mr_next = sAddr;
          if (sAddr[MR_BL_HI:MR_BL_LO] != BL4_CODE && sAddr[MR_BL_HI:MR_BL_LO] != BL8_CODE)
          begin
            badBurst_next = 1'b1;
          end
          if (sAddr[MR_DLLRST] && dll_reg != DLL_OFF)
          begin
            dll_next = DLL_LOCKING;
            lockCnt_next = '0;
          end
        end
        BA_EMR1:
        begin
          emr1_next = sAddr;
          if (sAddr[E1_DLLDIS])
          begin
            dll_next = DLL_OFF;
          end
          else if (dll_reg == DLL_OFF)
          begin
            dll_next = DLL_LOCKING;
            lockCnt_next = '0;
          end
        end
        BA_EMR2: emr2_next = sAddr;
        BA_EMR3: emr3_next = sAddr;
        default: written_next = written_reg;
      endcase
    end
    else if (srEntry)
    begin
      sref_next = 1'b1;
      dll_next = DLL_OFF;
    end
    else if (srExit)
    begin
      sref_next = 1'b0;
      dll_next = DLL_LOCKING;
      lockCnt_next = '0;
    end
    else if (linkEdge && dll_reg == DLL_LOCKING)
    begin
      // Lock time counts link clocks, so a slow link clock lengthens it
      if (lockCnt_reg == LOCK_LAST)
      begin
        dll_next = DLL_LOCKED;
      end
      else
      begin
        lockCnt_next = lockCnt_reg + LOCK_ONE;
      end
    end
    dllOn_next = dll_next != DLL_OFF;
    dllLocked_next = dll_next == DLL_LOCKED;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      clkPrev_reg <= 1'b0;
      ckePrev_reg <= 1'b0;
      mr_reg <= '0;
      emr1_reg <= '0;
      emr2_reg <= '0;
      emr3_reg <= '0;
      written_reg <= '0;
      badBurst_reg <= 1'b0;
      dll_reg <= DLL_OFF;
      lockCnt_reg <= '0;
      selfRefresh <= 1'b0;
      dllOn <= 1'b0;
      dllLocked <= 1'b0;
    end
    else
    begin
      clkPrev_reg <= clkPrev_next;
      ckePrev_reg <= ckePrev_next;
      mr_reg <= mr_next;
      emr1_reg <= emr1_next;
      emr2_reg <= emr2_next;
      emr3_reg <= emr3_next;
      written_reg <= written_next;
      badBurst_reg <= badBurst_next;
      dll_reg <= dll_next;
      lockCnt_reg <= lockCnt_next;
      selfRefresh <= sref_next;
      dllOn <= dllOn_next;
      dllLocked <= dllLocked_next;
    end
  end

  // ============================================================
  // Field decode
  logic [3:0] burstLen;
  logic [31:0] decodeWord;
  logic [31:0] statusWord;

  always_comb
  begin
    case (mr_reg[MR_BL_HI:MR_BL_LO])
      BL4_CODE: burstLen = BL4_LEN;
      BL8_CODE: burstLen = BL8_LEN;
      default: burstLen = '0;
    endcase
    decodeWord = {10'h0, emr1_reg[E1_RTT1], emr1_reg[E1_RTT0], emr1_reg[E1_RDQS],
                  emr1_reg[E1_DQSDIS], emr1_reg[E1_RDS], emr1_reg[E1_OCD_HI:E1_OCD_LO],
                  emr1_reg[E1_AL_HI:E1_AL_LO], mr_reg[MR_WR_HI:MR_WR_LO], mr_reg[MR_BT],
                  mr_reg[MR_CL_HI:MR_CL_LO], burstLen};
    statusWord = '0;
    statusWord[ST_DLL_ON] = dllOn;
    statusWord[ST_LOCKED] = dllLocked;
    statusWord[ST_SREF] = selfRefresh;
    statusWord[ST_BADBL] = badBurst_reg;
    statusWord[ST_TEST] = mr_reg[MR_TM];
    statusWord[ST_WR_HI:ST_WR_LO] = written_reg;
  end

  // ============================================================
  // AHB-Lite slave, zero wait states
  logic addrPhase;
  logic dpWrite_next;
  logic [7:0] dpAddr_next;
  logic [31:0] hrdata_next;
  logic enable_next;
  logic [ADDR_W-1:0] rdField;

  assign addrPhase = hsel && htrans[HTRANS_ACT] && hready;

  always_comb
  begin
    dpWrite_next = addrPhase && hwrite && haddr[31:8] == 24'h0;
    dpAddr_next = haddr[7:0];
    enable_next = enable_reg;
    if (dpWrite_reg && dpAddr_reg == OFF_CTRL)
    begin
      enable_next = hwdata[CTRL_EN];
    end
    rdField = '0;
    hrdata_next = '0;
    if (addrPhase && !hwrite && haddr[31:8] == 24'h0)
    begin
      case (haddr[7:0])
        OFF_CTRL: hrdata_next[CTRL_EN] = enable_reg;
        OFF_MR: rdField = mr_reg;
        OFF_EMR1: rdField = emr1_reg;
        OFF_EMR2: rdField = emr2_reg;
        OFF_EMR3: rdField = emr3_reg;
        OFF_STATUS: hrdata_next = statusWord;
        OFF_DECODE: hrdata_next = decodeWord;
        default: hrdata_next = '0;
      endcase
      hrdata_next[ADDR_W-1:0] = hrdata_next[ADDR_W-1:0] | rdField;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      dpWrite_reg <= 1'b0;
      dpAddr_reg <= '0;
      enable_reg <= CTRL_EN_RST;
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else if (ce)
    begin
      dpWrite_reg <= dpWrite_next;
      dpAddr_reg <= dpAddr_next;
      enable_reg <= enable_next;
      hrdata <= hrdata_next;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ============================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_MR_TAKES_WORD: assert property (
    modeWrite && sBa == BA_MR |=> mr_reg == $past(sAddr))
    else $error("mode register did not take the written word");
  AST_EMR1_TAKES_WORD: assert property (
    modeWrite && sBa == BA_EMR1 |=> emr1_reg == $past(sAddr) && dllOn == !$past(sAddr[E1_DLLDIS]))
    else $error("extended register 1 or DLL enable wrong after write");
  AST_BL8_DECODE: assert property (
    modeWrite && sBa == BA_MR && sAddr[MR_BL_HI:MR_BL_LO] == BL8_CODE
    |=> burstLen == BL8_LEN && decodeWord[3:0] == BL8_LEN
        && badBurst_reg == ($past(badBurst_reg) && !$past(badBurstClr)))
    else $error("burst length eight not decoded");
  AST_BAD_BURST_FLAG: assert property (
    modeWrite && sBa == BA_MR && sAddr[MR_BL_HI:MR_BL_LO] == 3'h0 |=> badBurst_reg)
    else $error("illegal burst code not flagged");
  AST_DLL_RESET_UNLOCKS: assert property (
    modeWrite && sBa == BA_MR && sAddr[MR_DLLRST] && dllOn |=> dllOn && !dllLocked)
    else $error("DLL reset did not restart locking");
  AST_EMR1_KEEPS_MR: assert property (
    modeWrite && sBa != BA_MR |=> $stable(mr_reg))
    else $error("extended write disturbed the mode register");
  AST_SREF_DLL_OFF: assert property (
    srEntry |=> selfRefresh && !dllOn ##1 !dllLocked)
    else $error("self refresh entry left the DLL on");
  AST_SREF_EXIT_RESET: assert property (
    srExit |=> !selfRefresh && dllOn && !dllLocked && lockCnt_reg == '0)
    else $error("self refresh exit did not reset the DLL");
  AST_LOCK_TIME: assert property (
    $rose(dllLocked) |-> $past(lockCnt_reg) == LOCK_LAST && $past(dll_reg) == DLL_LOCKING)
    else $error("DLL locked after wrong number of link clocks");
  AST_RDQS_FIELD: assert property (
    modeWrite && sBa == BA_EMR1 && !sAddr[E1_RDQS] |=> decodeWord[19] == 1'b0)
    else $error("read strobe enable shown while written low");

  COV_DLL_RESET: cover property (modeWrite && sBa == BA_MR && sAddr[MR_DLLRST]);
  COV_LOCKED: cover property ($rose(dllLocked));
  COV_SREF_CYCLE: cover property (srEntry ##[1:1000] srExit);
  COV_AHB_READ: cover property (addrPhase && !hwrite && haddr[7:0] == OFF_STATUS);
endmodule : dimr_core

// ==== hdl/dimr_pkg.sv ====
// ============================================================
// Shared constants for the DDR2 mode register block
package dimr_pkg;
  // Pin widths
  localparam int ADDR_W = 14;
  localparam int BA_W = 3;
  localparam int CMD_W = 4;
  localparam int SYNC_W = 1 + 1 + CMD_W + BA_W + ADDR_W;
  // Bank selects of the mode writes
  localparam logic [2:0] BA_MR = 3'h0;
  localparam logic [2:0] BA_EMR1 = 3'h1;
  localparam logic [2:0] BA_EMR2 = 3'h2;
  localparam logic [2:0] BA_EMR3 = 3'h3;
  // Command codes as {cs, ras, cas, we}, all active low
  localparam logic [3:0] CMD_MODE = 4'h0;
  localparam logic [3:0] CMD_REFRESH = 4'h1;
  // Mode register fields
  localparam int MR_BL_HI = 2;
  localparam int MR_BL_LO = 0;
  localparam int MR_BT = 3;
  localparam int MR_CL_HI = 6;
  localparam int MR_CL_LO = 4;
  localparam int MR_TM = 7;
  localparam int MR_DLLRST = 8;
  localparam int MR_WR_HI = 11;
  localparam int MR_WR_LO = 9;
  localparam logic [2:0] BL4_CODE = 3'h2;
  localparam logic [2:0] BL8_CODE = 3'h3;
  localparam logic [3:0] BL4_LEN = 4'h4;
  localparam logic [3:0] BL8_LEN = 4'h8;
  // Extended register 1 fields
  localparam int E1_DLLDIS = 0;
  localparam int E1_RDS = 1;
  localparam int E1_RTT0 = 2;
  localparam int E1_AL_HI = 5;
  localparam int E1_AL_LO = 3;
  localparam int E1_RTT1 = 6;
  localparam int E1_OCD_HI = 9;
  localparam int E1_OCD_LO = 7;
  localparam int E1_DQSDIS = 10;
  localparam int E1_RDQS = 11;
  // DLL lock time in link clocks
  localparam int DLL_LOCK_CLKS = 200;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MR = 8'h04;
  localparam logic [7:0] OFF_EMR1 = 8'h08;
  localparam logic [7:0] OFF_EMR2 = 8'h0c;
  localparam logic [7:0] OFF_EMR3 = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_DECODE = 8'h18;
  // Control and status bits
  localparam int CTRL_EN = 0;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam int ST_DLL_ON = 0;
  localparam int ST_LOCKED = 1;
  localparam int ST_SREF = 2;
  localparam int ST_BADBL = 3;
  localparam int ST_TEST = 4;
  localparam int ST_WR_LO = 8;
  localparam int ST_WR_HI = 11;
  localparam int HTRANS_ACT = 1;
  typedef enum logic [1:0] {DLL_OFF, DLL_LOCKING, DLL_LOCKED} dimr_dll_e;
endpackage : dimr_pkg

// ==== hdl/dimr_sync.sv ====
`timescale 1ns/10ps
// ============================================================
// Two-stage synchroniser for pins from outside the mclk domain
module dimr_sync #(
  parameter int WIDTH = 1
)
(
  // System
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage_reg;
  logic [WIDTH-1:0] stage_next;
  logic [WIDTH-1:0] dout_next;

  always_comb
  begin
    stage_next = ce ? din : stage_reg;
    dout_next = ce ? stage_reg : dout;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stage_reg <= '0;
      dout <= '0;
    end
    else
    begin
      stage_reg <= stage_next;
      dout <= dout_next;
    end
  end
endmodule : dimr_sync

// ==== sim/dimr_ctrl_model.sv ====
`timescale 1ns/10ps
// ============================================================
// Controller side: link clock runs free, commands leave on the
// falling edge so they are settled long before the sampling edge
module dimr_ctrl_model
  import dimr_pkg::*;
#(
  parameter int PWR_CLKS = 500,
  parameter int MRD_GAP = 2
)
(
  // Link clock and clock enable
  output logic memClk,
  output logic cke,
  // Command
  output logic csN,
  output logic rasN,
  output logic casN,
  output logic weN,
  // Bank and address
  output logic [BA_W-1:0] ba,
  output logic [ADDR_W-1:0] addr
);
  initial
  begin
    memClk = 1'b0;
    cke = 1'b0;
    {csN, rasN, casN, weN} = 4'hf;
    ba = 3'h0;
    addr = 14'h0;
    #137;
    forever #200 memClk = ~memClk;
  end

  // Released lines are turned over so a stale value cannot pass
  task automatic send(input logic [3:0] cmd, input logic [2:0] b, input logic [13:0] a);
    @(negedge memClk);
    {csN, rasN, casN, weN} <= cmd;
    ba <= b;
    addr <= a;
    @(negedge memClk);
    {csN, rasN, casN, weN} <= 4'hf;
    ba <= ~b;
    addr <= ~a;
    repeat (MRD_GAP) @(negedge memClk);
  endtask : send

  task automatic setCke(input logic v);
    @(negedge memClk);
    cke <= v;
  endtask : setCke

  task automatic enterSref();
    @(negedge memClk);
    cke <= 1'b0;
    {csN, rasN, casN, weN} <= CMD_REFRESH;
    @(negedge memClk);
    {csN, rasN, casN, weN} <= 4'hf;
  endtask : enterSref

  task automatic initSeq(input logic [13:0] mr, input logic [13:0] e1);
    repeat (PWR_CLKS) @(negedge memClk);
    setCke(1'b1);
    repeat (2) @(negedge memClk);
    send(4'h2, 3'h0, 14'h0400);
    send(CMD_MODE, BA_EMR2, 14'h0);
    send(CMD_MODE, BA_EMR3, 14'h0);
    send(CMD_MODE, BA_EMR1, e1 & 14'h1c7e);
    send(CMD_MODE, BA_MR, mr | 14'h0100);
    send(4'h2, 3'h0, 14'h0400);
    repeat (2) send(CMD_REFRESH, 3'h0, 14'h0);
    send(CMD_MODE, BA_MR, mr & 14'h3eff);
    repeat (200) @(negedge memClk);
    send(CMD_MODE, BA_EMR1, e1 | 14'h0380);
    send(CMD_MODE, BA_EMR1, e1 & 14'h3c7f);
  endtask : initSeq
endmodule : dimr_ctrl_model

// ==== sim/testbench.sv ====
`timescale 1ns/10ps
// ============================================================
// Link traffic from the controller model, registers over AHB-Lite
module testbench
  import dimr_pkg::*;
;
  localparam int LOCK = 4;
  localparam int LIMIT = 20000;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic memClk, cke, csN, rasN, casN, weN;
  logic [BA_W-1:0] ba;
  logic [ADDR_W-1:0] addr;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, dllOn, dllLocked, selfRefresh;
  int n_mismatch = 0;
  int n_tests = 0;
  int cycles = 0;

  always #25 mclk = ~mclk;

  dimr_ctrl_model dimr_ctrl_model_i (.memClk, .cke, .csN, .rasN, .casN, .weN, .ba, .addr);

  dimr_core #(.LOCK_CLKS(LOCK)) dimr_core_i (
    .mclk, .rst, .ce(1'b1), .memClk, .cke, .csN, .rasN, .casN, .weN, .ba, .addr,
    .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hready(hreadyout), .hwdata,
    .hrdata, .hreadyout, .hresp, .dllOn, .dllLocked, .selfRefresh);

  // ============================================================
  // Reporting
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // ============================================================
  // Bus and link helpers
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rdv);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(nm, x, exp);
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask : rd

  task automatic mode(input logic [2:0] b, input logic [13:0] a);
    dimr_ctrl_model_i.send(CMD_MODE, b, a);
  endtask : mode

  // Sampled mid-cycle so registered updates have landed
  task automatic pins(input logic [2:0] exp, input int waitLink);
    repeat (waitLink) @(negedge memClk);
    @(negedge mclk);
    chk("sref lock on", {29'h0, selfRefresh, dllLocked, dllOn}, {29'h0, exp});
  endtask : pins

  // ============================================================
  // Scenarios
  task automatic tReset();
    rd("status", OFF_STATUS, 32'h0);
    wr(8'h1c, 32'hffff_ffff);
    wr(OFF_MR, 32'h3fff);
    rd("unmapped", 8'h1c, 32'h0);
    rd("mr", OFF_MR, 32'h0);
    rd("ctrl", OFF_CTRL, 32'h1);
  endtask : tReset

  task automatic tInit();
    dimr_ctrl_model_i.initSeq(14'h0853, 14'h0c16);
    rd("mr", OFF_MR, 32'h853);
    rd("emr1", OFF_EMR1, 32'hc16);
    rd("emr2", OFF_EMR2, 32'h0);
    rd("status", OFF_STATUS, 32'hf03);
    rd("decode", OFF_DECODE, 32'h1e1458);
    pins(3'h3, 0);
  endtask : tInit

  task automatic tBurst();
    logic [2:0] code [3] = '{3'h2, 3'h3, 3'h5};
    logic [3:0] len [3] = '{4'h4, 4'h8, 4'h0};
    for (int i = 0; i < 3; i++)
    begin
      mode(BA_MR, {11'h10a, code[i]});
      rd("burst", OFF_DECODE, {28'h1e145, len[i]});
    end
    rd("status", OFF_STATUS, 32'hf0b);
    wr(OFF_STATUS, 32'h8);
    mode(BA_MR, 14'h08db);
    rd("status", OFF_STATUS, 32'hf13);
    rd("decode", OFF_DECODE, 32'h1e14d8);
    mode(BA_MR, 14'h0853);
    rd("emr1", OFF_EMR1, 32'hc16);
  endtask : tBurst

  task automatic tDll();
    mode(BA_MR, 14'h0953);
    pins(3'h1, 0);
    pins(3'h3, 6);
    mode(BA_EMR1, 14'h0c17);
    pins(3'h0, 0);
    mode(BA_MR, 14'h0953);
    pins(3'h0, 0);
    mode(BA_EMR1, 14'h0c16);
    pins(3'h1, 0);
    pins(3'h3, 6);
  endtask : tDll

  task automatic tSref();
    dimr_ctrl_model_i.enterSref();
    pins(3'h4, 2);
    mode(BA_MR, 14'h0852);
    rd("mr", OFF_MR, 32'h953);
    dimr_ctrl_model_i.setCke(1'b1);
    pins(3'h1, 2);
    pins(3'h3, 6);
  endtask : tSref

  task automatic tCtrl();
    wr(OFF_CTRL, 32'h0);
    rd("ctrl", OFF_CTRL, 32'h0);
    mode(BA_MR, 14'h0852);
    rd("mr", OFF_MR, 32'h953);
    wr(OFF_CTRL, 32'h1);
    mode(BA_MR, 14'h0852);
    rd("decode", OFF_DECODE, 32'h1e1454);
    mode(BA_EMR2, 14'h0080);
    rd("emr2", OFF_EMR2, 32'h80);
    rd("emr3", OFF_EMR3, 32'h0);
  endtask : tCtrl

  initial
  begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    tReset();
    tInit();
    tBurst();
    tDll();
    tSref();
    tCtrl();
    tally_and_finish();
  end
endmodule : testbench
